/* inc/psa_consts.svh */
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH
// Register byte offsets on the Wishbone slave
`define PSA_A_TPAG   8'h00
`define PSA_A_WPAG   8'h04
`define PSA_A_CPUCTL 8'h08
`define PSA_A_FCTL   8'h0c
`define PSA_A_KEY    8'h10
`define PSA_A_TEA    8'h14
`define PSA_A_TWD    8'h18
`define PSA_A_TCMD   8'h1c
`define PSA_A_TRD    8'h20
`define PSA_A_WEA    8'h24
`define PSA_A_WRD    8'h28
`define PSA_A_STAT   8'h2c
// Field positions
`define PSA_CW_EN    2
`define PSA_FC_WR    15
`define PSA_FC_WREN  14
`define PSA_FC_ERR   13
`define PSA_FC_ERASE 6
`define PSA_TP_CFG   7
`define PSA_TC_BYTE  2
// Encodings and values
`define PSA_KEY1     8'h55
`define PSA_KEY2     8'haa
`define PSA_OP_ROW   4'h1
`define PSA_OP_PAGE  4'h2
`define PSA_OP_WORD  4'h3
`define PSA_T_RDL    2'h0
`define PSA_T_RDH    2'h1
`define PSA_T_WTL    2'h2
`define PSA_T_WTH    2'h3
`define PSA_ERASED   24'hffffff
`define PSA_ID_ADDR  24'hff0000
// Counts: row and erase block sizes in words, table write cycles
`define PSA_ROW_WORDS 64
`define PSA_BLK_WORDS 512
`define PSA_TW_CYC    2
`endif

/* inc/psa_pkg.sv */
package psa_pkg;
  // One-hot controller states
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_TR1  = 8'h02,
    S_TR2  = 8'h04,
    S_TW1  = 8'h08,
    S_TW2  = 8'h10,
    S_WN1  = 8'h20,
    S_WN2  = 8'h40,
    S_PRG  = 8'h80
  } psa_state_e;

  // Whole register state of the top module
  typedef struct packed {
    psa_state_e  st;
    logic        ack;
    logic [31:0] rdat;
    logic [7:0]  tpag;
    logic [7:0]  wpag;
    logic [15:0] cpuctl;
    logic        fc_wr;
    logic        fc_wren;
    logic        fc_err;
    logic        fc_erase;
    logic [3:0]  fc_op;
    logic [1:0]  key;
    logic [15:0] tea;
    logic [15:0] twd;
    logic [1:0]  top;
    logic        tbyte;
    logic [15:0] trd;
    logic [15:0] wea;
    logic [15:0] wrd;
    logic [8:0]  cnt;
    logic        stl;
    logic [1:0]  pen;
  } psa_regs_s;
endpackage : psa_pkg

/* design/psa_prog_mem.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Program array: 24-bit words, registered read, one write port
module psa_prog_mem #(
  parameter int AW = 12                 // Word address width
) (
  input  wire logic          clk,       // System clock
  input  wire logic [AW-1:0] rd_addr,   // Read word index
  output logic      [23:0]   rd_q,      // Read data, one cycle later
  input  wire logic          wr_en,     // Write strobe
  input  wire logic [AW-1:0] wr_addr,   // Write word index
  input  wire logic [23:0]   wr_data    // Write data
);
  logic [23:0] mem [0:(1<<AW)-1];       // Array contents, not reset

  // One fetch per cycle; writes come only from the programming engine
  always_ff @(posedge clk) begin
    rd_q <= mem[rd_addr];
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule : psa_prog_mem

/* design/psa_row_latch.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Row holding latches, byte-masked writes, combinational read
module psa_row_latch #(
  parameter int IW = 6                  // Latch index width
) (
  input  wire logic          clk,       // System clock
  input  wire logic          we,        // Latch write strobe
  input  wire logic [IW-1:0] wi,        // Latch written
  input  wire logic [2:0]    wm,        // Byte mask, bit 2 is upper byte
  input  wire logic [23:0]   wd,        // Write data
  input  wire logic [IW-1:0] ri,        // Latch read
  output logic      [23:0]   rq         // Read data
);
  // Power up unknown on purpose: software pads unused words itself
  logic [23:0] lat [0:(1<<IW)-1];

  // Later writes overwrite earlier ones byte by byte
  always_ff @(posedge clk) begin
    for (int b = 0; b < 3; b++) begin
      if (we && wm[b]) begin
        lat[wi][b*8 +: 8] <= wd[b*8 +: 8];
      end
    end
  end

  assign rq = lat[ri];
endmodule : psa_row_latch

/* design/psa_top.sv */
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "psa_consts.svh"
////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - Word low read returns program bits unchanged
// R2 - Byte low read picks byte by select
// R3 - Word high read: upper byte, zero top
// R4 - Byte high read: upper byte or zero
// R5 - Page bit 7 selects configuration space
// R6 - Configuration writes ignored; only ID reads
// R7 - Program address steps two per word
// R8 - Window needs address bit 15 and enable
// R9 - Window address is page over 15 bits
// R10 - Window read costs one extra cycle
// R11 - Window read returns low 16 bits
// R12 - Window suspended during table operations
// R13 - Outside repeat: move one, others two
// R14 - In repeat: edges two, otherwise none
// R15 - Rows 64 words, aligned row/block bases
// R16 - Table writes fill latches, not array
// R17 - Software fills row; partial rows allowed
// R18 - Software pads unused latches with ones
// R19 - Latches any order, later write replaces
// R20 - Table write takes two cycles
// R21 - Table address is page over address
// R22 - Software writes two unlock keys first
// R23 - Start bit stalls, clears when done
// R24 - Configuration write leaves latches, no stall
module psa_top import psa_pkg::*; #(
  parameter int          AW     = 12,         // Array word index width
  parameter logic [23:0] DEV_ID = 24'h00a5c3  // Arbitrary ID value
) (
  input  wire logic        ref_clk,          // System clock
  input  wire logic        rst,              // Async reset, high
  input  wire logic        wb_cyc_i,         // Bus cycle
  input  wire logic        wb_stb_i,         // Bus strobe
  input  wire logic        wb_we_i,          // Bus write
  input  wire logic [7:0]  wb_adr_i,         // Byte address
  input  wire logic [3:0]  wb_sel_i,         // Byte enables
  input  wire logic [31:0] wb_dat_i,         // Write data
  output logic      [31:0] wb_dat_o,         // Read data
  output logic             wb_ack_o,         // Bus acknowledge
  input  wire logic        ins_win,          // Instruction uses window
  input  wire logic        ins_mov,          // It is a move or double move
  input  wire logic        ins_rep,          // It runs in a repeat loop
  input  wire logic        ins_edge,         // First/last/int exit/reentry
  output logic             stall_o,          // Processor stall
  output logic      [1:0]  added_cycles_o    // Extra instruction cycles
);
  ////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (AW < 9 || AW > 22) begin : g_chk
    $error("psa_top: AW must lie in 9..22");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(logic [15:0] o,
                                          logic [31:0] d,
                                          logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge16

  // Program word index from a 24-bit byte-style address
  function automatic logic [AW-1:0] widx(logic [23:0] a);
    widx = a[AW:1];                      // see R7
  endfunction : widx

  // Added cycles for a window-using instruction
  function automatic logic [1:0] penalty(logic w, logic m, logic rp,
                                         logic e);
    if (!w) begin
      penalty = 2'h0;
    end else if (!rp) begin
      penalty = m ? 2'h1 : 2'h2;         // see R13
    end else begin
      penalty = e ? 2'h2 : 2'h0;         // see R14
    end
  endfunction : penalty

  ////////////////////////////////////////////////////////////////////////
  // State and datapath signals
  psa_regs_s      r;                     // Current state
  psa_regs_s      n;                     // Next state
  logic           req;                   // New bus request
  logic           cmd_wr;                // Table command write accepted
  logic [23:0]    taddr;                 // Table target address
  logic [23:0]    waddr;                 // Window target address
  logic           cfg;                   // Table page in config space
  logic [23:0]    word;                  // Word seen by a table read
  logic [AW-1:0]  m_ra;                  // Array read index
  logic [23:0]    m_q;                   // Array read data
  logic           m_we;                  // Array write strobe
  logic [AW-1:0]  m_wa;                  // Array write index
  logic [23:0]    m_wd;                  // Array write data
  logic           l_we;                  // Latch write strobe
  logic [2:0]     l_wm;                  // Latch byte mask
  logic [23:0]    l_wd;                  // Latch write data
  logic [5:0]     l_ri;                  // Latch read index
  logic [23:0]    l_q;                   // Latch read data
  logic [AW-1:0]  base;                  // Aligned programming base
  logic [8:0]     last;                  // Last programming step

  assign taddr = {r.tpag, r.tea};                 // see R21
  assign waddr = {1'b0, r.wpag, r.wea[14:0]};     // see R9
  assign cfg   = r.tpag[`PSA_TP_CFG];             // see R5

  ////////////////////////////////////////////////////////////////////////
  // Program array and row latches
  psa_prog_mem #(.AW(AW)) u_mem (
    .clk     (ref_clk),
    .rd_addr (m_ra),
    .rd_q    (m_q),
    .wr_en   (m_we),
    .wr_addr (m_wa),
    .wr_data (m_wd)
  );

  psa_row_latch #(.IW(6)) u_lat (
    .clk (ref_clk),
    .we  (l_we),
    .wi  (r.tea[6:1]),
    .wm  (l_wm),
    .wd  (l_wd),
    .ri  (l_ri),
    .rq  (l_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: controller first, then the bus; in an FCTL write a failed
  // start sets the error flag after the software write, so the set wins
  always_comb begin
    n      = r;
    n.ack  = 1'b0;
    req    = wb_cyc_i && wb_stb_i && !r.ack;
    cmd_wr = 1'b0;
    m_ra   = widx(taddr);
    m_we   = 1'b0;
    m_wd   = `PSA_ERASED;
    l_we   = 1'b0;
    l_wm   = 3'h0;
    l_wd   = {r.twd[7:0], r.twd};
    l_ri   = r.cnt[5:0];
    // Config space reads only hit the ID word, all else reads zero
    word   = cfg ? ((taddr[23:1] == `PSA_ID_ADDR >> 1) ? DEV_ID
                                                      : 24'h000000)
                 : m_q;                                // see R6
    // Row, block or single word base, aligned from address zero
    case (r.fc_op)
      `PSA_OP_ROW:  begin
        base = widx(taddr) & ~AW'(`PSA_ROW_WORDS - 1); // see R15
        last = 9'(`PSA_ROW_WORDS - 1);
      end
      `PSA_OP_PAGE: begin
        base = widx(taddr) & ~AW'(`PSA_BLK_WORDS - 1); // see R15
        last = 9'(`PSA_BLK_WORDS - 1);
      end
      default: begin
        base = widx(taddr);
        last = 9'h000;
      end
    endcase
    m_wa = base + AW'(r.cnt);
    n.pen = penalty(ins_win, ins_mov, ins_rep, ins_edge);

    case (r.st)
      // Fetch presented; result formatted next cycle
      S_TR1: begin
        n.st = S_TR2;
      end
      S_TR2: begin
        n.st = S_IDLE;
        if (r.top == `PSA_T_RDL) begin
          if (r.tbyte) begin
            n.trd = {8'h00, r.tea[0] ? word[15:8] : word[7:0]}; // see R2
          end else begin
            n.trd = word[15:0];                                // see R1
          end
        end else if (r.tbyte && r.tea[0]) begin
          n.trd = 16'h0000;                                    // see R4
        end else begin
          n.trd = {8'h00, word[23:16]};                   // see R3 R4
        end
      end
      // Latch write in the first of two cycles, never the array
      S_TW1: begin
        n.st = S_TW2;
        l_we = 1'b1;                                   // see R16 R19
        if (r.top == `PSA_T_WTL) begin
          l_wm = r.tbyte ? (r.tea[0] ? 3'h2 : 3'h1) : 3'h3;
          l_wd = {8'h00, r.tbyte ? {2{r.twd[7:0]}} : r.twd};
        end else begin
          l_wm = (r.tbyte && r.tea[0]) ? 3'h0 : 3'h4;
        end
      end
      S_TW2: begin
        n.st = S_IDLE;                                 // see R20
      end
      // Two fetches for one window read, low word kept
      S_WN1: begin
        m_ra = widx(waddr);
        n.st = S_WN2;                                  // see R10
      end
      S_WN2: begin
        m_ra  = widx(waddr);
        n.wrd = m_q[15:0];                             // see R11
        n.st  = S_IDLE;
      end
      // Self-timed program or erase, one word per cycle
      S_PRG: begin
        m_we = 1'b1;
        if (!r.fc_erase) begin
          m_wd = (r.fc_op == `PSA_OP_WORD) ? l_q : l_q;
          l_ri = (r.fc_op == `PSA_OP_WORD) ? r.tea[6:1] : r.cnt[5:0];
        end
        n.cnt = r.cnt + 9'h001;
        if (r.cnt == last) begin
          n.st    = S_IDLE;
          n.fc_wr = 1'b0;                              // see R23
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase

    // Bus slave: answer every request one cycle later
    if (req) begin
      n.ack  = 1'b1;
      n.rdat = 32'h00000000;
      if (wb_we_i) begin
        // Any other write breaks the unlock pair
        n.key = 2'h0;
        case (wb_adr_i)
          `PSA_A_TPAG:   n.tpag = wb_sel_i[0] ? wb_dat_i[7:0] : r.tpag;
          `PSA_A_WPAG:   n.wpag = wb_sel_i[0] ? wb_dat_i[7:0] : r.wpag;
          `PSA_A_CPUCTL: n.cpuctl = merge16(r.cpuctl, wb_dat_i, wb_sel_i);
          `PSA_A_TEA:    n.tea = merge16(r.tea, wb_dat_i, wb_sel_i);
          `PSA_A_TWD:    n.twd = merge16(r.twd, wb_dat_i, wb_sel_i);
          `PSA_A_WEA:    begin
            n.wea = merge16(r.wea, wb_dat_i, wb_sel_i);
            // Window only when idle, enabled and in upper data space
            if (r.st != S_IDLE) begin
              n.wea = r.wea;                           // see R12
            end else if (n.wea[15] && r.cpuctl[`PSA_CW_EN]) begin
              n.st = S_WN1;                            // see R8
            end else begin
              n.wrd = 16'h0000;
            end
          end
          `PSA_A_KEY: begin
            if (wb_dat_i[7:0] == `PSA_KEY1) begin
              n.key = 2'h1;
            end else if (wb_dat_i[7:0] == `PSA_KEY2 && r.key == 2'h1) begin
              n.key = 2'h2;                            // see R22
            end
          end
          `PSA_A_TCMD: begin
            if (r.st == S_IDLE && wb_sel_i[0]) begin
              cmd_wr  = 1'b1;
              n.top   = wb_dat_i[1:0];
              n.tbyte = wb_dat_i[`PSA_TC_BYTE];
              if (!wb_dat_i[1]) begin
                n.st = S_TR1;
              end else if (!cfg) begin
                n.st = S_TW1;
              end                                      // see R24
            end
          end
          `PSA_A_FCTL: begin
            n.key = 2'h0;
            if (wb_sel_i[0]) begin
              n.fc_erase = wb_dat_i[`PSA_FC_ERASE];
              n.fc_op    = wb_dat_i[3:0];
            end
            if (wb_sel_i[1]) begin
              n.fc_wren = wb_dat_i[`PSA_FC_WREN];
              n.fc_err  = wb_dat_i[`PSA_FC_ERR];
              if (wb_dat_i[`PSA_FC_WR] && !r.fc_wr) begin
                if (r.key == 2'h2 && r.fc_wren && r.st == S_IDLE) begin
                  n.fc_wr = 1'b1;
                  n.cnt   = 9'h000;
                  n.st    = S_PRG;                     // see R23
                end else begin
                  n.fc_err = 1'b1;
                end
              end
            end
            // Unknown operation codes finish at once
            if (n.st == S_PRG &&
                !((n.fc_op == `PSA_OP_ROW  && !n.fc_erase) ||
                  (n.fc_op == `PSA_OP_PAGE &&  n.fc_erase) ||
                  (n.fc_op == `PSA_OP_WORD && !n.fc_erase))) begin
              n.st    = S_IDLE;
              n.fc_wr = 1'b0;
            end
          end
          default: ;
        endcase
      end else begin
        case (wb_adr_i)
          `PSA_A_TPAG:   n.rdat = {24'h0, r.tpag};
          `PSA_A_WPAG:   n.rdat = {24'h0, r.wpag};
          `PSA_A_CPUCTL: n.rdat = {16'h0, r.cpuctl};
          `PSA_A_FCTL:   n.rdat = {16'h0, r.fc_wr, r.fc_wren, r.fc_err,
                                   6'h00, r.fc_erase, 2'h0, r.fc_op};
          `PSA_A_TEA:    n.rdat = {16'h0, r.tea};
          `PSA_A_TWD:    n.rdat = {16'h0, r.twd};
          `PSA_A_TCMD:   n.rdat = {29'h0, r.tbyte, r.top};
          `PSA_A_TRD:    n.rdat = {16'h0, r.trd};
          `PSA_A_WEA:    n.rdat = {16'h0, r.wea};
          `PSA_A_WRD:    n.rdat = {16'h0, r.wrd};
          `PSA_A_STAT:   n.rdat = {29'h0, r.key == 2'h2, r.st == S_PRG,
                                   r.st != S_IDLE};
          default:       n.rdat = 32'h00000000;
        endcase
      end
    end
    n.stl = (n.st == S_PRG);                           // see R23
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r    <= '0;
      r.st <= S_IDLE;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o       = r.rdat;
  assign wb_ack_o       = r.ack;
  assign stall_o        = r.stl;
  assign added_cycles_o = r.pen;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_tw_two: assert property (r.st == S_TW1 |=>                 // see R20
      r.st == S_TW2 ##1 r.st == S_IDLE)
    else $error("table write not two cycles");
  a_win_two: assert property (r.st == S_WN1 |=>                // see R10
      r.st == S_WN2 ##1 r.st == S_IDLE)
    else $error("window read not two fetches");
  a_rdh_zero: assert property (r.st == S_TR2 &&                // see R3
      r.top == `PSA_T_RDH |=> r.trd[15:8] == 8'h00)
    else $error("high read phantom byte not zero");
  a_rdl_word: assert property (r.st == S_TR2 && !cfg &&        // see R1
      r.top == `PSA_T_RDL && !r.tbyte |=> r.trd == $past(m_q[15:0]))
    else $error("low word read altered");
  a_cfg_nowr: assert property (cmd_wr && wb_dat_i[1] && cfg    // see R24
      |=> r.st == S_IDLE && !stall_o)
    else $error("config write took effect");
  a_lat_cfg: assert property (l_we |-> !cfg)                    // see R6
    else $error("latch written in config space");
  a_stall_prg: assert property (stall_o == (r.st == S_PRG))     // see R23
    else $error("stall does not track programming");
  a_wr_clear: assert property ($fell(stall_o) |-> !r.fc_wr)     // see R23
    else $error("start bit not cleared at end");
  a_win_gate: assert property (r.st == S_WN1 |->                // see R8
      r.wea[15] && $past(r.cpuctl[`PSA_CW_EN]))
    else $error("window used while disabled");
  a_pen_move: assert property (ins_win && ins_mov && !ins_rep   // see R13
      |=> added_cycles_o == 2'h1)
    else $error("move penalty not one cycle");
endmodule : psa_top

/* test/psa_cpu_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Processor model: register traffic as a Wishbone master, plus the flags
// describing the instruction now executing
`include "psa_consts.svh"
module psa_cpu_model (
  input  wire logic        clk,    // System clock
  input  wire logic [31:0] dat_i,  // Read data from the block
  input  wire logic        ack_i,  // Acknowledge from the block
  output logic             cyc,    // Bus cycle
  output logic             stb,    // Bus strobe
  output logic             we,     // Bus write
  output logic      [7:0]  adr,    // Byte address
  output logic      [3:0]  sel,    // Byte enables
  output logic      [31:0] dat,    // Write data
  output logic      [3:0]  ins     // Window, move, repeat, loop edge
);
  // Idle bus at time zero
  initial begin
    {cyc, stb, we, adr, sel, dat, ins} = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One classic cycle; everything held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'h3;
    dat <= {16'h0000, d};
    do @(posedge clk); while (ack_i !== 1'b1);
    q = dat_i[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released lines must not keep looking valid
    dat <= ~dat;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    xfer(1'b0, a, 16'h0000, q);
  endtask : rd
  // Instruction flags change right after an edge, like the bus
  task automatic set_ins(input logic [3:0] v);
    ins <= v;
  endtask : set_ins
  // Control word, then the key pair with nothing between, then start
  task automatic start(input logic [15:0] ctl);
    wr(`PSA_A_FCTL, ctl);
    wr(`PSA_A_KEY, 16'h0055);
    wr(`PSA_A_KEY, 16'h00aa);
    wr(`PSA_A_FCTL, ctl | 16'h8000);
  endtask : start
endmodule : psa_cpu_model

/* test/tb.sv */
`timescale 1ns/1ps
`include "psa_consts.svh"
module tb;
  localparam logic [23:0] ID = 24'h3c5a96;  // Arbitrary identity value
  logic        ref_clk;      // System clock
  logic        rst;          // Reset, high
  logic        cyc, stb, we; // Bus controls
  logic [7:0]  adr;          // Bus address
  logic [3:0]  sel;          // Byte enables
  logic [31:0] wdat, rdat;   // Bus data
  logic        ack, stall;   // Answers
  logic [3:0]  ins;          // Instruction flags
  logic [1:0]  added;        // Added cycles
  logic [15:0] q;            // Last value read
  int          err_count, compares, stall_cnt;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  psa_top #(.DEV_ID(ID)) dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ins_win(ins[3]),
    .ins_mov(ins[2]), .ins_rep(ins[1]), .ins_edge(ins[0]),
    .stall_o(stall), .added_cycles_o(added));
  psa_cpu_model cpu (.clk(ref_clk), .dat_i(rdat), .ack_i(ack), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat), .ins(ins));
  // Count stalled cycles of the processor
  always @(posedge ref_clk) begin
    if (stall === 1'b1) stall_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Poll a status bit until clear, bounded; running out is a mismatch
  task automatic wait_clr(input logic [7:0] a, input int b);
    for (int i = 0; i < 600; i++) begin
      cpu.rd(a, q);
      if (q[b] === 1'b0) return;
    end
    err_count++;
    $display("ERROR wait bit %0d expected 0 seen 1", b);
  endtask : wait_clr
  // Table operation: command {byte, op} at effective address ea
  task automatic tbl(input logic [2:0] cmd, input logic [15:0] ea);
    cpu.wr(`PSA_A_TEA, ea);
    cpu.wr(`PSA_A_TCMD, {13'h0000, cmd});
    wait_clr(`PSA_A_STAT, 0);
    cpu.rd(`PSA_A_TRD, q);
  endtask : tbl
  task automatic t_reset;
    cpu.rd(`PSA_A_FCTL, q);
    chk("fctl reset", 16'h0000, q);
    cpu.rd(`PSA_A_CPUCTL, q);
    chk("cpuctl reset", 16'h0000, q);
    cpu.rd(8'hfc, q);
    chk("unmapped", 16'h0000, q);
    $display("test reset done");
  endtask : t_reset
  // Latch loads, word program, then every read form at word 8
  task automatic t_table;
    int s0;
    cpu.wr(`PSA_A_TPAG, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      cpu.wr(`PSA_A_TWD, i == 1 ? 16'h1234 : 16'h1111);
      tbl(3'h2, 16'h0010);
    end
    cpu.wr(`PSA_A_TWD, 16'h0056);
    tbl(3'h3, 16'h0010);
    s0 = stall_cnt;
    cpu.start(16'h4003);
    wait_clr(`PSA_A_FCTL, 15);
    chk("stall cycles", 16'd1, 16'(stall_cnt - s0));
    cpu.wr(`PSA_A_TWD, 16'h9999);
    tbl(3'h2, 16'h0010);
    tbl(3'h0, 16'h0010);
    chk("read low word", 16'h1234, q);
    tbl(3'h4, 16'h0010);
    chk("read low byte0", 16'h0034, q);
    tbl(3'h4, 16'h0011);
    chk("read low byte1", 16'h0012, q);
    tbl(3'h1, 16'h0010);
    chk("read high word", 16'h0056, q);
    tbl(3'h5, 16'h0010);
    chk("read high byte0", 16'h0056, q);
    tbl(3'h5, 16'h0011);
    chk("read high byte1", 16'h0000, q);
    $display("test table done");
  endtask : t_table
  // Identity reads; a write there must not reach the latches
  task automatic t_config;
    cpu.wr(`PSA_A_TPAG, 16'h00ff);
    tbl(3'h0, 16'h0000);
    chk("id low", ID[15:0], q);
    tbl(3'h1, 16'h0000);
    chk("id high", {8'h00, ID[23:16]}, q);
    cpu.wr(`PSA_A_TWD, 16'h7777);
    tbl(3'h2, 16'h0010);
    cpu.wr(`PSA_A_TPAG, 16'h0000);
    cpu.start(16'h4003);
    wait_clr(`PSA_A_FCTL, 15);
    tbl(3'h0, 16'h0010);
    chk("config write", 16'h9999, q);
    $display("test config done");
  endtask : t_config
  // Window reads with and without the enable and address bit 15
  task automatic t_window;
    cpu.wr(`PSA_A_WPAG, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      cpu.wr(`PSA_A_CPUCTL, i == 1 ? 16'h0000 : 16'h0004);
      cpu.wr(`PSA_A_WEA, i == 2 ? 16'h0010 : 16'h8010);
      wait_clr(`PSA_A_STAT, 0);
      cpu.rd(`PSA_A_WRD, q);
      chk("window", i == 0 ? 16'h9999 : 16'h0000, q);
    end
    $display("test window done");
  endtask : t_window
  // Block erase with a window request held off, then a padded row
  task automatic t_flash;
    int s0;
    s0 = stall_cnt;
    cpu.start(16'h4042);
    cpu.wr(`PSA_A_WEA, 16'h8010);
    wait_clr(`PSA_A_FCTL, 15);
    chk("erase stall", 16'd512, 16'(stall_cnt - s0));
    cpu.rd(`PSA_A_WEA, q);
    chk("window held off", 16'h0010, q);
    tbl(3'h0, 16'h0010);
    chk("erased word", 16'hffff, q);
    for (int i = 0; i < 64; i++) begin
      cpu.wr(`PSA_A_TWD, i == 4 ? 16'h4321 : 16'hffff);
      tbl(3'h2, 16'(2 * i));
      tbl(3'h3, 16'(2 * i));
    end
    s0 = stall_cnt;
    cpu.start(16'h4001);
    wait_clr(`PSA_A_FCTL, 15);
    chk("row stall", 16'd64, 16'(stall_cnt - s0));
    tbl(3'h0, 16'h0008);
    chk("row word", 16'h4321, q);
    tbl(3'h1, 16'h0008);
    chk("row high", 16'h0021, q);
    $display("test flash done");
  endtask : t_flash
  // Every flag combination against the added cycle count
  task automatic t_penalty;
    logic [1:0] e;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      cpu.set_ins(i[3:0]);
      @(posedge ref_clk);
      @(negedge ref_clk);
      e = !i[3] ? 2'd0 : !i[1] ? (i[2] ? 2'd1 : 2'd2) : (i[0] ? 2'd2 : 2'd0);
      chk("added cycles", {14'h0, e}, {14'h0, added});
    end
    $display("test penalty done");
  endtask : t_penalty
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // Watchdog well beyond the expected run
  initial begin
    #(30000 * 100);
    err_count++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_table();
    t_config();
    t_window();
    t_flash();
    t_penalty();
    stop_test();
  end
endmodule : tb
